// *** core/isf_params.svh ***
// constants for the input selector and offset removal filter control
`ifndef ISF_PARAMS_SVH
`define ISF_PARAMS_SVH

// register indices
`define ISF_REG_POWER      2'h0
`define ISF_REG_SELECT     2'h1
`define ISF_REG_STATUS     2'h2
`define ISF_REG_CORNER     2'h3

// power register fields
`define ISF_POW_ADC_L      0
`define ISF_POW_ADC_R      1
`define ISF_POW_DAC        2

// select register fields
`define ISF_SEL_LEFT_LO    0
`define ISF_SEL_RIGHT_LO   2
`define ISF_SEL_LDIFF      4
`define ISF_SEL_RDIFF      5

// reset values
`define ISF_POWER_RST      3'h0
`define ISF_SELECT_RST     6'h00

// corner frequency in millihertz at the reference rate, rate in hertz
`define ISF_CORNER_MHZ     900
`define ISF_REF_FS_HZ      44100

`endif

// *** core/isf_pkg.sv ***
// types for the input selector and offset removal filter control
package isf_pkg;

  // route for one microphone amplifier channel
  typedef enum logic [2:0] {
    ISF_RT_IN1  = 3'h0,
    ISF_RT_IN2  = 3'h1,
    ISF_RT_IN3  = 3'h3,
    ISF_RT_IN4  = 3'h2,
    ISF_RT_DIFF = 3'h6,
    ISF_RT_NONE = 3'h7
  } isf_route_t;

  // which path the filter runs on
  typedef enum logic [1:0] {
    ISF_FP_OFF = 2'h0,
    ISF_FP_ADC = 2'h1,
    ISF_FP_DAC = 2'h3
  } isf_fpath_t;

endpackage

// *** core/isf_ctrl_if.sv ***
// carrier between the register file and the route decoder
`timescale 1ns/1ps
interface isf_ctrl_if;
  logic [1:0] left_input_select;
  logic [1:0] right_input_select;
  logic       left_diff_select;
  logic       right_diff_select;
  logic [2:0] left_route;
  logic [2:0] right_route;
  logic       route_valid;

  modport ctrl (
    output left_input_select, right_input_select,
    output left_diff_select, right_diff_select,
    input  left_route, right_route, route_valid
  );
  modport dec (
    input  left_input_select, right_input_select,
    input  left_diff_select, right_diff_select,
    output left_route, right_route, route_valid
  );
endinterface

// *** core/isf_route_dec.sv ***
// registered decoder from select bits to input routes
`timescale 1ns/1ps
module isf_route_dec
  import isf_pkg::*;
(
  // clock and reset
  input  wire logic clk,
  input  wire logic reset,
  // selector bits in, routes out
  isf_ctrl_if.dec   sel
);

  typedef struct packed {
    isf_route_t left_route;
    isf_route_t right_route;
    logic       route_valid;
  } isf_dec_state_t;

  isf_dec_state_t st;
  isf_dec_state_t next_st;

  function automatic isf_route_t code_route(input logic [1:0] code);
    case (code)
      2'h0:    code_route = ISF_RT_IN1;
      2'h1:    code_route = ISF_RT_IN2;
      2'h2:    code_route = ISF_RT_IN3;
      default: code_route = ISF_RT_IN4;
    endcase
  endfunction

  always_comb begin
    next_st = st;
    next_st.left_route  = ISF_RT_NONE;
    next_st.right_route = ISF_RT_NONE;
    next_st.route_valid = 1'b0;
    case ({sel.left_diff_select, sel.right_diff_select})
      2'b00: begin
        next_st.left_route  = code_route(sel.left_input_select);
        next_st.right_route = code_route(sel.right_input_select);
        next_st.route_valid = 1'b1;
      end
      2'b11: begin
        // pair one on left, pair two on right
        if (sel.left_input_select == 2'h0 &&
            sel.right_input_select == 2'h0) begin
          next_st.left_route  = ISF_RT_DIFF;
          next_st.right_route = ISF_RT_DIFF;
          next_st.route_valid = 1'b1;
        end
      end
      2'b10: begin
        if (sel.left_input_select == 2'h0 &&
            sel.right_input_select != 2'h0) begin
          next_st.left_route  = ISF_RT_DIFF;
          next_st.right_route = code_route(sel.right_input_select);
          next_st.route_valid = 1'b1;
        end
      end
      default: begin
        // input two on the left is taken by the right pair
        if (sel.right_input_select == 2'h0 &&
            sel.left_input_select != 2'h1) begin
          next_st.left_route  = code_route(sel.left_input_select);
          next_st.right_route = ISF_RT_DIFF;
          next_st.route_valid = 1'b1;
        end
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      st <= '{ISF_RT_IN1, ISF_RT_IN1, 1'b1};
    end else begin
      st <= next_st;
    end
  end

  assign sel.left_route  = st.left_route;
  assign sel.right_route = st.right_route;
  assign sel.route_valid = st.route_valid;

endmodule

// *** core/isf_top.sv ***
// filter path enable and input selector control with register port
`timescale 1ns/1ps
`include "isf_params.svh"
module isf_top
  import isf_pkg::*;
#(
  parameter int FS_HZ = 44100
)(
  // clock and reset
  input  wire logic       clk,
  input  wire logic       reset,
  // register port
  input  wire logic [1:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_write,
  input  wire logic       reg_read,
  output logic      [7:0] reg_rdata,
  // filter path enables
  output logic            adc_filter_enable,
  output logic            dac_filter_enable,
  // channel routes
  output logic      [2:0] left_route,
  output logic      [2:0] right_route,
  output logic            route_valid
);

  // ***************************************************************
  // state
  // ***************************************************************
  typedef struct packed {
    logic       adc_left_power;
    logic       adc_right_power;
    logic       dac_power;
    logic [1:0] left_input_select;
    logic [1:0] right_input_select;
    logic       left_diff_select;
    logic       right_diff_select;
    isf_fpath_t fpath;
    logic       adc_filter_enable;
    logic       dac_filter_enable;
    logic [7:0] rdata;
  } isf_state_t;

  isf_state_t st;
  isf_state_t next_st;

  // corner scales with rate; the filter itself lives in the datapath
  localparam int CORNER_MHZ =
    (`ISF_CORNER_MHZ * FS_HZ) / `ISF_REF_FS_HZ;

  isf_ctrl_if ctl ();

  isf_route_dec i_isf_route_dec (
    .clk   (clk),
    .reset (reset),
    .sel   (ctl.dec)
  );

  assign ctl.left_input_select  = st.left_input_select;
  assign ctl.right_input_select = st.right_input_select;
  assign ctl.left_diff_select   = st.left_diff_select;
  assign ctl.right_diff_select  = st.right_diff_select;

  // ***************************************************************
  // next state
  // ***************************************************************
  always_comb begin
    next_st = st;
    next_st.rdata = 8'h00;
    if (reg_write) begin
      if (reg_addr == `ISF_REG_POWER) begin
        next_st.adc_left_power  = reg_wdata[`ISF_POW_ADC_L];
        next_st.adc_right_power = reg_wdata[`ISF_POW_ADC_R];
        next_st.dac_power       = reg_wdata[`ISF_POW_DAC];
      end else if (reg_addr == `ISF_REG_SELECT) begin
        // any combination is stored; the decoder flags bad ones
        next_st.left_input_select  = reg_wdata[`ISF_SEL_LEFT_LO +: 2];
        next_st.right_input_select = reg_wdata[`ISF_SEL_RIGHT_LO +: 2];
        next_st.left_diff_select   = reg_wdata[`ISF_SEL_LDIFF];
        next_st.right_diff_select  = reg_wdata[`ISF_SEL_RDIFF];
      end
    end
    if (reg_read) begin
      if (reg_addr == `ISF_REG_POWER) begin
        next_st.rdata = {5'h00, st.dac_power, st.adc_right_power,
                         st.adc_left_power};
      end else if (reg_addr == `ISF_REG_SELECT) begin
        next_st.rdata = {2'h0, st.right_diff_select, st.left_diff_select,
                         st.right_input_select, st.left_input_select};
      end else if (reg_addr == `ISF_REG_STATUS) begin
        next_st.rdata = {ctl.route_valid, ctl.right_route,
                         1'b0, ctl.left_route} ^ 8'h00;
        next_st.rdata[3] = st.fpath[1];
        next_st.rdata[7] = ctl.route_valid;
      end else if (reg_addr == `ISF_REG_CORNER) begin
        next_st.rdata = 8'(CORNER_MHZ / 10);
      end
    end
    // enables are held in flops beside the path code so outputs stay glitch free
    if (st.adc_left_power || st.adc_right_power) begin
      next_st.fpath             = ISF_FP_ADC;
      next_st.adc_filter_enable = 1'b1;
      next_st.dac_filter_enable = 1'b0;
    end else if (st.dac_power) begin
      next_st.fpath             = ISF_FP_DAC;
      next_st.adc_filter_enable = 1'b0;
      next_st.dac_filter_enable = 1'b1;
    end else begin
      next_st.fpath             = ISF_FP_OFF;
      next_st.adc_filter_enable = 1'b0;
      next_st.dac_filter_enable = 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      st <= '{1'b0, 1'b0, 1'b0, 2'h0, 2'h0, 1'b0, 1'b0,
              ISF_FP_OFF, 1'b0, 1'b0, 8'h00};
    end else begin
      st <= next_st;
    end
  end

  // ***************************************************************
  // outputs
  // ***************************************************************
  assign reg_rdata         = st.rdata;
  assign adc_filter_enable = st.adc_filter_enable;
  assign dac_filter_enable = st.dac_filter_enable;
  assign left_route        = ctl.left_route;
  assign right_route       = ctl.right_route;
  assign route_valid       = ctl.route_valid;

endmodule

// *** dv/isf_top_properties.sv ***
// port assertions for the selector and filter path control
`timescale 1ns/1ps
module isf_top_properties
  import isf_pkg::*;
(
  // clock and reset
  input wire logic       clk,
  input wire logic       reset,
  // register port
  input wire logic [1:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic       reg_write,
  // filter and routes
  input wire logic       adc_filter_enable,
  input wire logic       dac_filter_enable,
  input wire logic [2:0] left_route,
  input wire logic [2:0] right_route,
  input wire logic       route_valid
);
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  logic wp;
  logic ws;
  assign wp = reg_write && reg_addr == 2'h0;
  assign ws = reg_write && reg_addr == 2'h1;
  adc_path_a: assert property (wp |-> ##2
    adc_filter_enable == |$past(reg_wdata[1:0], 2)) else $error("adc path");
  dac_path_a: assert property (wp |-> ##2
    dac_filter_enable == ($past(reg_wdata[2:0], 2) == 3'h4)) else $error("dac");
  one_path_a: assert property (!(adc_filter_enable && dac_filter_enable))
    else $error("both paths");
  plain_left_a: assert property (ws && reg_wdata[5:4] == 2'h0 |-> ##2
    route_valid && left_route == {1'b0, $past(reg_wdata[1], 2),
    $past(^reg_wdata[1:0], 2)}) else $error("plain route");
  both_diff_a: assert property (ws && reg_wdata[5:0] == 6'h30 |-> ##2
    route_valid && left_route == ISF_RT_DIFF && right_route == ISF_RT_DIFF)
    else $error("both pairs");
  left_diff_a: assert property (ws && reg_wdata[5:4] == 2'h1 &&
    reg_wdata[1:0] == 2'h0 && reg_wdata[3:2] != 2'h0 |-> ##2
    route_valid && left_route == ISF_RT_DIFF) else $error("left pair");
  no_route_a: assert property (!route_valid |-> left_route == ISF_RT_NONE
    && right_route == ISF_RT_NONE) else $error("no route");
endmodule

bind isf_top isf_top_properties i_isf_top_properties (.clk(clk),
  .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_write(reg_write), .adc_filter_enable(adc_filter_enable),
  .dac_filter_enable(dac_filter_enable), .left_route(left_route),
  .right_route(right_route), .route_valid(route_valid));

// *** dv/isf_top_tb.sv ***
// self-checking bench for the selector and filter path control
`timescale 1ns/1ps
module isf_top_tb;
  logic       clk = 1'b0;
  logic       reset = 1'b1;
  logic [1:0] reg_addr = 2'h0;
  logic [7:0] reg_wdata = 8'h00;
  logic       reg_write = 1'b0;
  logic       reg_read = 1'b0;
  logic [7:0] reg_rdata;
  logic       adc_en;
  logic       dac_en;
  logic [2:0] l_rt;
  logic [2:0] r_rt;
  logic       valid;
  int         err_total = 0;
  int         num_checks = 0;
  int         cycles = 0;
  always #5 clk = ~clk;
  isf_top i_isf_top (.clk(clk), .reset(reset), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
    .reg_rdata(reg_rdata), .adc_filter_enable(adc_en),
    .dac_filter_enable(dac_en), .left_route(l_rt), .right_route(r_rt),
    .route_valid(valid));
  // ****************
  // bus and checks
  // ****************
  task automatic chk(input string what, input logic [7:0] exp, got);
    num_checks++;
    if (got !== exp) begin
      err_total++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask
  // waits out the two-edge latency so outputs can be judged on return
  task automatic wr(input logic [1:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge clk);
    reg_write <= 1'b0;
    repeat (2) @(posedge clk);
    #1;
  endtask
  task automatic rd(input logic [1:0] a, output logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge clk);
    reg_read <= 1'b0;
    #1;
    d = reg_rdata;
  endtask
  function automatic logic [2:0] gray(input logic [1:0] c);
    return {1'b0, c[1], ^c};
  endfunction
  function automatic logic [7:0] exp_st(input logic [5:0] s);
    logic [2:0] l;
    logic [2:0] r;
    logic       v;
    l = s[4] ? 3'h6 : gray(s[1:0]);
    r = s[5] ? 3'h6 : gray(s[3:2]);
    v = 1'b1;
    if (s[4]) v = s[1:0] == 0 && (s[5] ? s[3:2] == 0 : s[3:2] != 0);
    else if (s[5]) v = s[3:2] == 0 && s[1:0] != 1;
    if (!v) begin
      l = 3'h7;
      r = 3'h7;
    end
    return {v, r, 1'b1, l};
  endfunction
  // ****************
  // scenarios
  // ****************
  task automatic t_reset();
    logic [7:0] d;
    chk("enables", 8'h00, {6'h00, adc_en, dac_en});
    chk("routes", 8'h80, {valid, r_rt, 1'b0, l_rt});
    rd(2'h1, d);
    chk("select", 8'h00, d);
  endtask
  // the corner register is read-only, so a write must leave it alone
  task automatic t_corner();
    logic [7:0] d;
    rd(2'h3, d);
    chk("corner", 8'h5A, d);
    wr(2'h3, 8'h00);
    rd(2'h3, d);
    chk("corner kept", 8'h5A, d);
  endtask
  task automatic t_filter();
    logic [7:0] d;
    for (int p = 0; p < 8; p++) begin
      wr(2'h0, 8'(p));
      chk("adc enable", {7'h00, |p[1:0]}, {7'h00, adc_en});
      chk("dac enable", {7'h00, p == 4}, {7'h00, dac_en});
      rd(2'h0, d);
      chk("power", 8'(p), d);
    end
  endtask
  task automatic t_select();
    logic [7:0] d;
    wr(2'h0, 8'h04);
    for (int s = 0; s < 64; s++) begin
      wr(2'h1, 8'(s));
      rd(2'h2, d);
      chk("status", exp_st(6'(s)), d);
      chk("ports", exp_st(6'(s)), {valid, r_rt, dac_en, l_rt});
    end
  endtask
  // software flips between the two advised settings for pair one
  task automatic t_advised();
    logic [7:0] d;
    repeat (2) begin
      wr(2'h1, 8'h14);
      rd(2'h2, d);
      chk("advised pair", 8'h9E, d);
      wr(2'h1, 8'h05);
      rd(2'h2, d);
      chk("advised line", 8'h99, d);
    end
  endtask
  task automatic finish_test();
    $display("checks %0d errors %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  always @(posedge clk) begin
    cycles++;
    if (cycles == 3000) begin
      err_total++;
      finish_test();
    end
  end
  initial begin
    repeat (20) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    #1;
    t_reset();
    t_corner();
    t_filter();
    t_select();
    t_advised();
    finish_test();
  end
endmodule
